// File: seg_map.vh
// Constants for the SRAM error-correcting guard: widths, register indices, fields, codes
// Summary of operation
// - Every read of protected memory except a debug read runs the stored word through the error check.
// - A single-bit error returns corrected data to the requesting master.
// - The corrected word is written back, repairing the fault during that read.
// - Setting repair_disable suppresses the automatic corrected write-back.
// - A correctable single-bit error on a master read or a partial-write read sets single_err_flag; debug reads do not.
// - A double-bit error marks the returned word invalid.
// - After reset every memory word is written with zero and matching check bits.
// - During initialization memory accesses are held off and ready reads zero.
// - When initialization ends accesses are allowed and ready reads one.
// - Partial writes run as read-modify-write, only on initialized memory.
// - Unimplemented bits and reserved locations read as zero.
// - Registers decode at system-supplied base address plus their local offset.
`ifndef SEG_MAP_VH
`define SEG_MAP_VH

// ==========================================================
// Memory geometry and code
`define SEG_AW 12
`define SEG_DW 16
`define SEG_CW 6
`define SEG_HW 5
`define SEG_MW 22
`define SEG_LAST_WORD 12'hFFF
`define SEG_FULL_BE 2'h3
// Hamming column for data bits 15..0, five bits each
`define SEG_CODES 80'hAD27_28BD_CD62_D493_98A3

// ==========================================================
// Register bus decode
`define SEG_IDX_LSB 2
`define SEG_IDX_MSB 5
`define SEG_BASE_LSB 6
`define SEG_RESP_OKAY 2'h0
`define SEG_IDX_STATE 4'h0
`define SEG_IDX_IE 4'h1
`define SEG_IDX_IF 4'h2
`define SEG_IDX_PTRH 4'h7
`define SEG_IDX_PTRM 4'h8
`define SEG_IDX_PTRL 4'h9
`define SEG_IDX_DWH 4'hC
`define SEG_IDX_DWL 4'hD
`define SEG_IDX_CHK 4'hE
`define SEG_IDX_CMD 4'hF

// ==========================================================
// Register fields
`define SEG_CMD_RDIS 7
`define SEG_CMD_WR 1
`define SEG_CMD_RD 0
`define SEG_BIT0 0

`endif

// File: seg_secded.v
// Single-error-correct, double-error-detect code for 16 data and 6 check bits
`include "seg_map.vh"
`default_nettype none

module seg_secded (
	// Word to encode or check
	input wire [`SEG_DW-1:0] data_in,
	input wire [`SEG_CW-1:0] chk_in,
	// Results
	output wire [`SEG_CW-1:0] chk_gen,
	output wire [`SEG_DW-1:0] data_fix,
	output wire single_err,
	output wire double_err
);
	localparam [`SEG_DW*`SEG_HW-1:0] CODES = `SEG_CODES;

	wire [`SEG_HW-1:0] acc [0:`SEG_DW];
	wire [`SEG_HW-1:0] syn;
	wire [`SEG_DW-1:0] flip;
	wire odd;

	assign acc[0] = {`SEG_HW{1'b0}};
	assign syn = chk_in[`SEG_HW-1:0] ^ acc[`SEG_DW];
	assign odd = ^{data_in, chk_in};

	genvar i;
	generate
		for (i = 0; i < `SEG_DW; i = i + 1) begin : g_bit
			assign acc[i+1] = acc[i] ^ ({`SEG_HW{data_in[i]}} & CODES[i*`SEG_HW +: `SEG_HW]);
			assign flip[i] = odd & (syn == CODES[i*`SEG_HW +: `SEG_HW]);
		end
	endgenerate

	// Top check bit makes the whole word even, which tells one flip from two
	assign chk_gen = {^{data_in, acc[`SEG_DW]}, acc[`SEG_DW]};
	assign single_err = odd;
	assign double_err = ~odd & (|syn);
	assign data_fix = data_in ^ flip;
endmodule

`default_nettype wire

// File: seg_sram_ecc_guard.v
// SRAM error-correcting guard: master port, SRAM port, init sweep, AXI4-Lite registers
`include "seg_map.vh"
`default_nettype none

module seg_sram_ecc_guard (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Placement in the system map
	input wire [31:0] base_addr,
	// AXI4-Lite write address
	input wire [31:0] awaddr,
	input wire [2:0] awprot,
	input wire awvalid,
	output reg awready,
	// AXI4-Lite write data and response
	input wire [31:0] wdata,
	input wire [3:0] wstrb,
	input wire wvalid,
	output reg wready,
	output reg [1:0] bresp,
	output reg bvalid,
	input wire bready,
	// AXI4-Lite read
	input wire [31:0] araddr,
	input wire [2:0] arprot,
	input wire arvalid,
	output reg arready,
	output reg [31:0] rdata,
	output reg [1:0] rresp,
	output reg rvalid,
	input wire rready,
	// Bus master memory port
	input wire m_req,
	input wire m_we,
	input wire [`SEG_AW-1:0] m_addr,
	input wire [1:0] m_be,
	input wire [`SEG_DW-1:0] m_wdata,
	output reg m_ack,
	output reg m_rvalid,
	output reg [`SEG_DW-1:0] m_rdata,
	output reg m_rinvalid,
	// Synchronous SRAM, one cycle read latency
	output reg sram_en,
	output reg sram_we,
	output reg [`SEG_AW-1:0] sram_addr,
	output reg [`SEG_MW-1:0] sram_wdata,
	input wire [`SEG_MW-1:0] sram_rdata,
	// Interrupt
	output reg irq
);
	// ==========================================================
	// Local codes
	localparam [1:0] ST_INIT = 2'h0;
	localparam [1:0] ST_IDLE = 2'h1;
	localparam [1:0] ST_WAIT = 2'h2;
	localparam [1:0] ST_DATA = 2'h3;
	localparam [1:0] OP_MRD = 2'h0;
	localparam [1:0] OP_RMW = 2'h1;
	localparam [1:0] OP_DRD = 2'h2;

	// ==========================================================
	// State
	reg [1:0] state;
	reg [1:0] op;
	reg [`SEG_AW-1:0] init_addr;
	reg ready;
	reg [`SEG_AW-1:0] req_addr;
	reg [1:0] req_be;
	reg [`SEG_DW-1:0] req_wdata;

	// Software-visible registers
	reg single_err_irq_enable;
	reg single_err_flag;
	reg repair_disable;
	reg debug_write_cmd;
	reg debug_read_cmd;
	reg [22:0] debug_pointer;
	reg [`SEG_DW-1:0] debug_word;
	reg [`SEG_CW-1:0] debug_syndrome_bits;

	// ==========================================================
	// Code logic
	wire [`SEG_DW-1:0] dec_data;
	wire dec_single;
	wire dec_double;
	wire [`SEG_CW-1:0] enc_chk;
	reg [`SEG_DW-1:0] enc_in;
	wire [`SEG_DW-1:0] merged;

	// Check on every word coming back from the array
	seg_secded u_dec (
		.data_in(sram_rdata[`SEG_DW-1:0]),
		.chk_in(sram_rdata[`SEG_MW-1:`SEG_DW]),
		.chk_gen(),
		.data_fix(dec_data),
		.single_err(dec_single),
		.double_err(dec_double)
	);

	seg_secded u_enc (
		.data_in(enc_in),
		.chk_in({`SEG_CW{1'b0}}),
		.chk_gen(enc_chk),
		.data_fix(),
		.single_err(),
		.double_err()
	);

	// Unselected bytes come from the corrected old word, never the raw one
	assign merged = {req_be[1] ? req_wdata[15:8] : dec_data[15:8],
		req_be[0] ? req_wdata[7:0] : dec_data[7:0]};

	always @* begin
		case (state)
			ST_IDLE: enc_in = m_wdata;
			ST_DATA: enc_in = (op == OP_RMW) ? merged : dec_data;
			default: enc_in = {`SEG_DW{1'b0}};
		endcase
	end

	// Events shared between the sequencer and the register file
	wire in_data = (state == ST_DATA);
	wire sbe_set = in_data && (op != OP_DRD) && dec_single;
	wire dbg_wr_go = (state == ST_IDLE) && debug_write_cmd;
	wire dbg_rd_go = (state == ST_IDLE) && !debug_write_cmd && debug_read_cmd;
	wire dbg_rd_done = in_data && (op == OP_DRD);
	wire m_take = (state == ST_IDLE) && !debug_write_cmd && !debug_read_cmd && m_req && !m_ack;

	// ==========================================================
	// Access sequencer
	always @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_INIT;
			op <= OP_MRD;
			init_addr <= {`SEG_AW{1'b0}};
			ready <= 1'b0;
			req_addr <= {`SEG_AW{1'b0}};
			req_be <= 2'h0;
			req_wdata <= {`SEG_DW{1'b0}};
			m_ack <= 1'b0;
			m_rvalid <= 1'b0;
			m_rdata <= {`SEG_DW{1'b0}};
			m_rinvalid <= 1'b0;
			sram_en <= 1'b0;
			sram_we <= 1'b0;
			sram_addr <= {`SEG_AW{1'b0}};
			sram_wdata <= {`SEG_MW{1'b0}};
		end else begin
			sram_en <= 1'b0;
			sram_we <= 1'b0;
			m_ack <= 1'b0;
			m_rvalid <= 1'b0;
			m_rinvalid <= 1'b0;
			case (state)
				ST_INIT: begin
					// Zero sweep; no master is taken until it ends
					sram_en <= 1'b1;
					sram_we <= 1'b1;
					sram_addr <= init_addr;
					sram_wdata <= {enc_chk, {`SEG_DW{1'b0}}};
					init_addr <= init_addr + 1'b1;
					if (init_addr == `SEG_LAST_WORD) begin
						state <= ST_IDLE;
						ready <= 1'b1;
					end
				end
				ST_IDLE: begin
					if (dbg_wr_go) begin
						// Raw store lets software plant faults on purpose
						sram_en <= 1'b1;
						sram_we <= 1'b1;
						sram_addr <= debug_pointer[`SEG_AW-1:0];
						sram_wdata <= {debug_syndrome_bits, debug_word};
					end else if (dbg_rd_go) begin
						sram_en <= 1'b1;
						sram_addr <= debug_pointer[`SEG_AW-1:0];
						op <= OP_DRD;
						state <= ST_WAIT;
					end else if (m_take) begin
						m_ack <= 1'b1;
						req_addr <= m_addr;
						req_be <= m_be;
						req_wdata <= m_wdata;
						sram_en <= 1'b1;
						sram_addr <= m_addr;
						if (m_we && (m_be == `SEG_FULL_BE)) begin
							sram_we <= 1'b1;
							sram_wdata <= {enc_chk, m_wdata};
						end else if (m_we) begin
							op <= OP_RMW;
							state <= ST_WAIT;
						end else begin
							op <= OP_MRD;
							state <= ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					state <= ST_DATA;
				end
				ST_DATA: begin
					state <= ST_IDLE;
					case (op)
						OP_MRD: begin
							m_rvalid <= 1'b1;
							m_rdata <= dec_data;
							m_rinvalid <= dec_double;
							if (dec_single && !repair_disable) begin
								sram_en <= 1'b1;
								sram_we <= 1'b1;
								sram_addr <= req_addr;
								sram_wdata <= {enc_chk, dec_data};
							end
						end
						OP_RMW: begin
							// A double error leaves the word untouched so it stays detectable
							if (!dec_double) begin
								sram_en <= 1'b1;
								sram_we <= 1'b1;
								sram_addr <= req_addr;
								sram_wdata <= {enc_chk, merged};
							end
						end
						default: begin
						end
					endcase
				end
				default: begin
					state <= ST_INIT;
				end
			endcase
		end
	end

	// ==========================================================
	// AXI4-Lite decode
	wire aw_hit = (awaddr[31:`SEG_BASE_LSB] == base_addr[31:`SEG_BASE_LSB]);
	wire ar_hit = (araddr[31:`SEG_BASE_LSB] == base_addr[31:`SEG_BASE_LSB]);
	wire [3:0] widx = awaddr[`SEG_IDX_MSB:`SEG_IDX_LSB];
	wire [3:0] ridx = araddr[`SEG_IDX_MSB:`SEG_IDX_LSB];
	wire do_wr = awready && awvalid && wready && wvalid;
	wire wr_lane = do_wr && aw_hit && wstrb[0];
	wire [7:0] wb = wdata[7:0];
	wire clr_flag = wr_lane && (widx == `SEG_IDX_IF) && wb[`SEG_BIT0];
	wire cmd_wr = wr_lane && (widx == `SEG_IDX_CMD);
	reg [7:0] rd_byte;

	always @* begin
		rd_byte = 8'h00;
		if (ar_hit) begin
			case (ridx)
				`SEG_IDX_STATE: rd_byte = {7'h00, ready};
				`SEG_IDX_IE: rd_byte = {7'h00, single_err_irq_enable};
				`SEG_IDX_IF: rd_byte = {7'h00, single_err_flag};
				`SEG_IDX_PTRH: rd_byte = debug_pointer[22:15];
				`SEG_IDX_PTRM: rd_byte = debug_pointer[14:7];
				`SEG_IDX_PTRL: rd_byte = {debug_pointer[6:0], 1'b0};
				`SEG_IDX_DWH: rd_byte = debug_word[15:8];
				`SEG_IDX_DWL: rd_byte = debug_word[7:0];
				`SEG_IDX_CHK: rd_byte = {2'h0, debug_syndrome_bits};
				`SEG_IDX_CMD: rd_byte = {repair_disable, 5'h00, debug_write_cmd, debug_read_cmd};
				default: rd_byte = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Bus handshakes: address and data are taken together once both are offered
	always @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `SEG_RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rresp <= `SEG_RESP_OKAY;
			rdata <= 32'h0000_0000;
		end else begin
			awready <= 1'b0;
			wready <= 1'b0;
			arready <= 1'b0;
			if (awvalid && wvalid && !awready && !bvalid) begin
				awready <= 1'b1;
				wready <= 1'b1;
			end
			if (do_wr) begin
				bvalid <= 1'b1;
				bresp <= `SEG_RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
			if (arvalid && !arready && !rvalid) begin
				arready <= 1'b1;
			end
			if (arready && arvalid) begin
				rvalid <= 1'b1;
				rresp <= `SEG_RESP_OKAY;
				rdata <= {24'h00_0000, rd_byte};
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Register file
	always @(posedge aclk) begin
		if (!aresetn) begin
			single_err_irq_enable <= 1'b0;
			single_err_flag <= 1'b0;
			repair_disable <= 1'b0;
			debug_write_cmd <= 1'b0;
			debug_read_cmd <= 1'b0;
			debug_pointer <= 23'h00_0000;
			debug_word <= {`SEG_DW{1'b0}};
			debug_syndrome_bits <= {`SEG_CW{1'b0}};
			irq <= 1'b0;
		end else begin
			// A new error in the clearing cycle keeps the flag set
			single_err_flag <= sbe_set | (single_err_flag & ~clr_flag);
			irq <= single_err_flag & single_err_irq_enable;
			// Command bits self-clear when served; a fresh write wins over the clear
			debug_write_cmd <= (debug_write_cmd & ~dbg_wr_go) |
				(cmd_wr & wb[`SEG_CMD_WR]);
			debug_read_cmd <= (debug_read_cmd & ~dbg_rd_done) |
				(cmd_wr & wb[`SEG_CMD_RD]);
			if (cmd_wr) begin
				repair_disable <= wb[`SEG_CMD_RDIS];
			end
			if (wr_lane) begin
				case (widx)
					`SEG_IDX_IE: single_err_irq_enable <= wb[`SEG_BIT0];
					`SEG_IDX_PTRH: debug_pointer[22:15] <= wb;
					`SEG_IDX_PTRM: debug_pointer[14:7] <= wb;
					`SEG_IDX_PTRL: debug_pointer[6:0] <= wb[7:1];
					`SEG_IDX_DWH: debug_word[15:8] <= wb;
					`SEG_IDX_DWL: debug_word[7:0] <= wb;
					`SEG_IDX_CHK: debug_syndrome_bits <= wb[`SEG_CW-1:0];
					default: begin
					end
				endcase
			end
			// Raw load, no correction, so software sees exactly what is stored
			if (dbg_rd_done) begin
				debug_word <= sram_rdata[`SEG_DW-1:0];
				debug_syndrome_bits <= sram_rdata[`SEG_MW-1:`SEG_DW];
			end
		end
	end
endmodule

`default_nettype wire

// File: seg_guard_props.sv
// Checker for the SRAM error-correcting guard, bound to its ports
`include "seg_map.vh"
`default_nettype none
module seg_guard_props (
	// Clock and reset
	input wire aclk,
	input wire aresetn,
	// Register bus
	input wire [31:0] rdata,
	input wire rvalid,
	input wire rready,
	input wire [1:0] rresp,
	input wire bvalid,
	input wire [1:0] bresp,
	// Master port
	input wire m_ack,
	input wire m_we,
	input wire [1:0] m_be,
	input wire [`SEG_AW-1:0] m_addr,
	input wire [`SEG_DW-1:0] m_wdata,
	input wire m_rvalid,
	input wire [`SEG_DW-1:0] m_rdata,
	input wire m_rinvalid,
	// Memory port
	input wire sram_en,
	input wire sram_we,
	input wire [`SEG_AW-1:0] sram_addr,
	input wire [`SEG_MW-1:0] sram_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// Init sweep tracker: the sweep spans the first 4096 cycles
	logic [12:0] icnt;
	always_ff @(posedge aclk) begin
		if (!aresetn) icnt <= 13'h0000;
		else if (!icnt[12]) icnt <= icnt + 13'h0001;
	end
	// ==========================================================
	// Init sweep, master port and register bus
	sequence s_full_take;
		m_ack && m_we && m_be == 2'h3;
	endsequence
	sequence s_part_take;
		m_ack && m_we && m_be != 2'h3;
	endsequence
	a_init_zero: assert property (!icnt[12] && sram_en |-> sram_we
		&& sram_wdata == 22'h00_0000)
		else $error("init write not zero");
	a_init_hold: assert property (!icnt[12] |-> !m_ack)
		else $error("access taken during init");
	a_read_check: assert property (m_ack && !m_we |-> sram_en && !sram_we ##2 m_rvalid)
		else $error("read not checked in time");
	a_full_write: assert property (s_full_take |-> sram_we && sram_addr == m_addr
		&& sram_wdata[15:0] == m_wdata)
		else $error("full write wrong");
	a_rmw_read: assert property (s_part_take |-> sram_en && !sram_we ##2 !m_rvalid)
		else $error("partial write not read first");
	a_double_mark: assert property (m_rinvalid |-> m_rvalid && !sram_we)
		else $error("invalid mark misplaced");
	a_repair_data: assert property (m_rvalid && sram_we |-> sram_wdata[15:0] == m_rdata
		&& sram_addr == $past(sram_addr, 2))
		else $error("repair word wrong");
	a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer dropped");
	a_rdata_zero: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_bresp_okay: assert property (bvalid |-> bresp == `SEG_RESP_OKAY)
		else $error("write response not okay");
	a_rresp_okay: assert property (rvalid |-> rresp == `SEG_RESP_OKAY)
		else $error("read response not okay");
endmodule
bind seg_sram_ecc_guard seg_guard_props u_props (.aclk, .aresetn, .rdata, .rvalid, .rready,
	.rresp, .bvalid, .bresp, .m_ack, .m_we, .m_be, .m_addr, .m_wdata, .m_rvalid, .m_rdata,
	.m_rinvalid, .sram_en, .sram_we, .sram_addr, .sram_wdata);
`default_nettype wire

// File: seg_sram_model.sv
// Synchronous SRAM model at the guard's memory port
`include "seg_map.vh"
`default_nettype none
module seg_sram_model (
	// Clock
	input wire logic aclk,
	// Access
	input wire logic en,
	input wire logic we,
	input wire logic [`SEG_AW-1:0] addr,
	input wire logic [`SEG_MW-1:0] wdata,
	output logic [`SEG_MW-1:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [`SEG_MW-1:0] mem [0:4095];
	// Output is good for one cycle; then it flips so stale data cannot pass
	always @(posedge aclk) begin
		if (en && we) mem[addr] <= wdata;
		if (en && !we) rdata <= mem[addr];
		else rdata <= ~rdata;
	end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the SRAM error-correcting guard
`include "seg_map.vh"
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] BASE = 32'h4000_0000;
	logic aclk = 0;
	logic aresetn = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic m_req = 0, m_we = 0, inv;
	logic [11:0] m_addr = 0;
	logic [1:0] m_be = 0;
	logic [15:0] m_wdata = 0, d;
	logic [21:0] keep;
	wire awready, wready, bvalid, arready, rvalid, m_ack, m_rvalid, m_rinvalid;
	wire sram_en, sram_we, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [15:0] m_rdata;
	wire [11:0] sram_addr;
	wire [21:0] sram_wdata, sram_rdata;
	int mismatches = 0, checks_done = 0;
	time t0;
	seg_sram_ecc_guard uut (.aclk, .aresetn, .base_addr(BASE), .awaddr, .awprot(3'h0),
		.awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
		.araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .m_req,
		.m_we, .m_addr, .m_be, .m_wdata, .m_ack, .m_rvalid, .m_rdata, .m_rinvalid, .sram_en,
		.sram_we, .sram_addr, .sram_wdata, .sram_rdata, .irq);
	seg_sram_model u_sram (.aclk, .en(sram_en), .we(sram_we), .addr(sram_addr),
		.wdata(sram_wdata), .rdata(sram_rdata));
	initial forever #4 aclk = ~aclk;
	// ==========================================================
	// Bus tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic aw(input logic [31:0] a, input logic [7:0] b);
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h00_0000, b};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (bvalid !== 1'b1);
		bready <= 0;
	endtask
	function automatic logic [31:0] ra(input logic [3:0] i);
		return BASE + {26'h0, i, 2'h0};
	endfunction
	// A nonzero lag keeps rready low that many cycles after rvalid, so the answer must stand
	task automatic rchk(input logic [3:0] i, input logic [31:0] e, input int lag = 0);
		@(posedge aclk);
		araddr <= ra(i);
		arvalid <= 1;
		rready <= (lag == 0);
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (rvalid !== 1'b1);
		if (lag > 0) begin
			repeat (lag) @(posedge aclk);
			rready <= 1;
			@(posedge aclk);
		end
		rready <= 0;
		chk(rdata, e);
	endtask
	// Master request; a read leaves its answer in d and inv
	task automatic mreq(input logic we, input logic [11:0] a, input logic [1:0] be,
		input logic [15:0] wd);
		@(posedge aclk);
		m_req <= 1;
		m_we <= we;
		m_addr <= a;
		m_be <= be;
		m_wdata <= wd;
		do @(posedge aclk); while (m_ack !== 1'b1);
		m_req <= 0;
		if (!we) begin
			do @(posedge aclk); while (m_rvalid !== 1'b1);
			d = m_rdata;
			inv = m_rinvalid;
		end else repeat (3) @(posedge aclk);
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// Tests
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		rchk(`SEG_IDX_STATE, 0);
		t0 = $time;
		mreq(0, 12'hfff, 2'h3, 0);
		chk(($time - t0) > 32000, 1);
		chk({inv, d}, 0);
		chk(u_sram.mem[12'h07f], 0);
		rchk(`SEG_IDX_STATE, 1);
		aw(ra(`SEG_IDX_IE), 1);
		mreq(1, 12'h00a, 2'h3, 16'ha5c3);
		keep = u_sram.mem[10];
		u_sram.mem[10] = keep ^ 22'h00_0010;
		mreq(0, 12'h00a, 2'h3, 0);
		chk({inv, d}, 16'ha5c3);
		rchk(`SEG_IDX_IF, 1);
		chk(u_sram.mem[10], keep);
		chk(irq, 1);
		aw(ra(`SEG_IDX_IF), 1);
		rchk(`SEG_IDX_IF, 0);
		chk(irq, 0);
		// Repair off, interrupt masked
		aw(ra(`SEG_IDX_IE), 0);
		aw(ra(`SEG_IDX_CMD), 8'h80);
		rchk(`SEG_IDX_CMD, 32'h80);
		u_sram.mem[10] = keep ^ 22'h00_0001;
		mreq(0, 12'h00a, 2'h3, 0);
		chk(d, 16'ha5c3);
		rchk(`SEG_IDX_IF, 1);
		chk(irq, 0);
		chk(u_sram.mem[10], keep ^ 22'h00_0001);
		// Partial write merges with the corrected old word
		mreq(1, 12'h00a, 2'h1, 16'h00ff);
		aw(ra(`SEG_IDX_CMD), 0);
		mreq(0, 12'h00a, 2'h3, 0);
		chk({inv, d}, 16'ha5ff);
		u_sram.mem[10] = u_sram.mem[10] ^ 22'h00_0300;
		keep = u_sram.mem[10];
		mreq(0, 12'h00a, 2'h3, 0);
		chk(inv, 1);
		mreq(1, 12'h00a, 2'h2, 16'h7700);
		chk(u_sram.mem[10], keep);
		mreq(1, 12'h014, 2'h3, 16'h1234);
		mreq(1, 12'h014, 2'h1, 16'hffab);
		mreq(0, 12'h014, 2'h3, 0);
		chk(d, 16'h12ab);
		// Debug access to word 30
		aw(ra(`SEG_IDX_PTRH), 0);
		aw(ra(`SEG_IDX_PTRM), 0);
		aw(ra(`SEG_IDX_PTRL), 8'h3d);
		rchk(`SEG_IDX_PTRL, 32'h3c);
		aw(ra(`SEG_IDX_DWH), 8'h12);
		aw(ra(`SEG_IDX_DWL), 8'h34);
		aw(ra(`SEG_IDX_CHK), 8'hff);
		rchk(`SEG_IDX_CHK, 32'h3f);
		aw(ra(`SEG_IDX_CMD), 8'h02);
		rchk(`SEG_IDX_CMD, 0);
		chk(u_sram.mem[30], 22'h3f_1234);
		u_sram.mem[30] = 22'h0b_c3e1;
		aw(ra(`SEG_IDX_CMD), 8'h01);
		rchk(`SEG_IDX_CMD, 0);
		rchk(`SEG_IDX_DWH, 32'hc3);
		rchk(`SEG_IDX_DWL, 32'he1);
		rchk(`SEG_IDX_CHK, 32'h0b);
		// Decode: foreign base, reserved and read-only places
		aw(BASE + 32'h0000_0044, 1);
		rchk(`SEG_IDX_IE, 0);
		aw(ra(4'h5), 8'hff);
		for (int i = 3; i < 12; i++) if (i < 7 || i > 9) rchk(i[3:0], 0);
		aw(ra(`SEG_IDX_STATE), 0);
		rchk(`SEG_IDX_STATE, 1, 2);
		test_done();
	end
	// Whole run is about 4300 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		mismatches++;
		test_done();
	end
endmodule
`default_nettype wire
